/* File: dv/rtcirq_host_model.sv */
// host cpu stand-in: register writes and reads on the block's write and read ports
// assumes clk is the block's clock and tasks are entered 1 ns after a rising edge
`timescale 1ns/10ps

module rtcirq_host_model
  import rtcirq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] host_rd_data,
  output rtcirq_wr_s      host_wr,
  output logic [3:0]      host_rd_addr
);
  initial begin
    host_wr      = '0;
    host_rd_addr = 4'h0;
  end

  // one idle edge after each write so valid never re-rises in the same step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_wr = '{valid: 1'b1, addr: a, data: d};
    @(posedge clk);
    #1 host_wr.valid = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    host_rd_addr = a;
    @(posedge clk);
    @(posedge clk);
    #1 d = host_rd_data;
  endtask

  // alarm enables written off first with the other control bits at their new values, then to their values in ctrl
  task automatic arm(input logic [7:0] ctrl);
    wr(ADDR_IRQ_CTRL, ctrl & 8'h3F);
    wr(ADDR_IRQ_CTRL, ctrl);
  endtask
endmodule // rtcirq_host_model

/* File: dv/tb_top.sv */
// self-checking bench for the interrupt and clock-output logic
// assumes the crystal runs far faster than real so a 2 Hz half period fits the run
`timescale 1ns/10ps

module tb_top
  import rtcirq_pkg::*;
;
  logic         clk;
  logic         rst_n;
  logic         xtal_in;
  logic         week_m;
  logic         day_m;
  logic         osc_halt;
  logic         ce;
  logic         adj_len;
  logic         adj_sht;
  rtcirq_roll_s roll;
  rtcirq_wr_s   host_wr;
  logic [3:0]   rd_addr;
  logic [7:0]   rd_data;
  logic [7:0]   v;
  logic         sec_tick;
  logic         per_oe;
  logic         week_oe;
  logic         day_oe;
  logic         clk_oe;
  int           miscompares = 0;
  int           checks_done = 0;
  int           cycles      = 0;
  int           rises       = 0;
  int           ticks       = 0;
  int           oe_rises    = 0;
  int           i;
  int           n;
  logic [2:0]   tsel  [7] = '{3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h7, 3'h7};
  logic [3:0]   troll [7] = '{4'h0, 4'h7, 4'h8, 4'h8, 4'hC, 4'hE, 4'hF};
  logic         texp  [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  rtcirq_core i_rtcirq_core (.clk(clk), .rst_n(rst_n), .ce(ce), .xtal_in(xtal_in),
    .host_wr(host_wr), .host_rd_addr(rd_addr), .week_alarm_match(week_m),
    .daily_alarm_match(day_m), .roll(roll), .osc_halt_flag(osc_halt),
    .adj_lengthen(adj_len), .adj_shorten(adj_sht), .host_rd_data(rd_data), .sec_tick(sec_tick),
    .od_o(), .periodic_irq_n_oe(per_oe), .week_alarm_irq_n_oe(week_oe),
    .daily_alarm_irq_n_oe(day_oe), .crystal_clock_out_oe(clk_oe));

  rtcirq_host_model i_rtcirq_host_model (.clk(clk), .host_rd_data(rd_data),
    .host_wr(host_wr), .host_rd_addr(rd_addr));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // crystal half period unrelated to the system clock
  initial begin
    xtal_in = 1'b0;
    #7;
    forever #203 xtal_in = ~xtal_in;
  end

  always @(posedge xtal_in) rises++;
  always @(posedge clk_oe) oe_rises++;
  always @(posedge clk) begin
    if (sec_tick === 1'b1) ticks++;
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic w(input logic [3:0] a, input logic [7:0] d);
    i_rtcirq_host_model.wr(a, d);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    checks_done++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("wrong value at %0t: %s count %0d", $time, what, got);
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    i_rtcirq_host_model.rd(a, v);
    chk(v, exp, "register read");
  endtask

  task automatic hit(input logic wk, input logic dy);
    week_m = wk;
    day_m  = dy;
    @(posedge clk);
    #1 week_m = 1'b0;
    day_m = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_n    = 1'b0;
    week_m   = 1'b0;
    day_m    = 1'b0;
    osc_halt = 1'b0;
    roll     = '0;
    ce       = 1'b1;
    adj_len  = 1'b0;
    adj_sht  = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({5'h00, per_oe, week_oe, day_oe}, 8'h00, "idle pins");
    rchk(ADDR_IRQ_CTRL, CTRL_RESET);
    rchk(ADDR_IRQ_FLAG, FLAG_RESET);
    // clock enable low: the write is not taken
    ce = 1'b0;
    w(ADDR_IRQ_CTRL, 8'h80);
    ce = 1'b1;
    rchk(ADDR_IRQ_CTRL, CTRL_RESET);
    // alarms: daily disabled ignores its match
    i_rtcirq_host_model.arm(8'h80);
    hit(1'b1, 1'b1);
    rchk(ADDR_IRQ_FLAG, 8'h02);
    chk({6'h00, week_oe, day_oe}, 8'h02, "alarm pins");
    w(ADDR_IRQ_FLAG, 8'hF7);
    rchk(ADDR_IRQ_FLAG, 8'hF2);
    w(ADDR_IRQ_FLAG, 8'h00);
    rchk(ADDR_IRQ_FLAG, 8'h00);
    chk({7'h00, week_oe}, 8'h00, "week released");
    rchk(ADDR_IRQ_CTRL, 8'h80);
    i_rtcirq_host_model.arm(8'hC0);
    hit(1'b1, 1'b1);
    rchk(ADDR_IRQ_FLAG, 8'h03);
    chk({6'h00, week_oe, day_oe}, 8'h03, "both alarm pins");
    // clear landing on the same edge as new matches on both channels
    fork
      w(ADDR_IRQ_FLAG, 8'h00);
      hit(1'b1, 1'b1);
    join
    rchk(ADDR_IRQ_FLAG, 8'h03);
    osc_halt = 1'b1;
    @(posedge clk);
    #1 osc_halt = 1'b0;
    rchk(ADDR_IRQ_CTRL, 8'h00);
    rchk(ADDR_IRQ_FLAG, 8'h00);
    // clock out: stops only with both disable bits set
    for (i = 0; i < 4; i++) begin
      w(ADDR_IRQ_CTRL, {3'h0, i[1], 4'h0});
      w(ADDR_IRQ_FLAG, {4'h0, i[0], 3'h0});
      n = oe_rises;
      repeat (40) @(posedge clk);
      #1;
      if (i == 3) chk_rng(oe_rises - n, 0, 0, "clock out off");
      else chk_rng(oe_rises - n, 7, 11, "clock out on");
    end
    w(ADDR_IRQ_FLAG, 8'h00);
    w(ADDR_IRQ_CTRL, {5'h00, SEL_LOW});
    chk({7'h00, per_oe}, 8'h01, "fixed low");
    w(ADDR_IRQ_CTRL, {5'h00, SEL_OFF});
    chk({7'h00, per_oe}, 8'h00, "off");
    // level modes: one tick after the divider restart, with an event only where the roll inputs meet the select
    for (i = 0; i < 7; i++) begin
      roll = troll[i];
      w(ADDR_IRQ_CTRL, {5'h00, tsel[i]});
      w(ADDR_SECONDS, 8'h00);
      w(ADDR_IRQ_FLAG, 8'h00);
      n = ticks;
      chk({7'h00, per_oe}, 8'h00, "level cleared");
      repeat (6) @(posedge xtal_in);
      repeat (4) @(posedge clk);
      #1;
      chk_rng(ticks - n, 1, 1, "seconds tick");
      rchk(ADDR_IRQ_FLAG, {5'h00, texp[i], 2'h0});
      chk({7'h00, per_oe}, {7'h00, texp[i]}, "level pin");
    end
    roll = '0;
    // adjustment: a held divider never reaches the tick, double steps jump over it
    for (i = 0; i < 3; i++) begin
      adj_len = (i == 0);
      adj_sht = (i == 1);
      w(ADDR_SECONDS, 8'h00);
      n = ticks;
      repeat (6) @(posedge xtal_in);
      repeat (4) @(posedge clk);
      #1;
      chk_rng(ticks - n, i / 2, i / 2, "adjusted tick");
    end
    w(ADDR_IRQ_CTRL, {5'h00, SEL_2HZ});
    w(ADDR_SECONDS, 8'h00);
    chk({7'h00, per_oe}, 8'h01, "pulse restart low");
    n = rises;
    while (per_oe === 1'b1 && cycles < 59000) begin
      @(posedge clk);
      #1;
    end
    chk_rng(rises - n, 8190, 8196, "2 Hz low half");
    w(ADDR_IRQ_CTRL, {5'h00, SEL_1HZ});
    chk({7'h00, per_oe}, 8'h01, "1 Hz low half");
    finish_test();
  end
endmodule // tb_top

/* File: hdl/rtcirq_core.sv */
// interrupt outputs, periodic interrupt and gated crystal clock output of the rtc
// assumes serial bus slave, time counters and alarm comparators run on clk;
// the crystal square wave arrives asynchronously and is synchronised here
`timescale 1ns/10ps

module rtcirq_core
  import rtcirq_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         xtal_in,
  input  wire rtcirq_wr_s   host_wr,
  input  wire logic [3:0]   host_rd_addr,
  input  wire logic         week_alarm_match,
  input  wire logic         daily_alarm_match,
  input  wire rtcirq_roll_s roll,
  input  wire logic         osc_halt_flag,
  input  wire logic         adj_lengthen,
  input  wire logic         adj_shorten,
  output logic [7:0]        host_rd_data,
  output logic              sec_tick,
  output logic [3:0]        od_o,
  output logic              periodic_irq_n_oe,
  output logic              week_alarm_irq_n_oe,
  output logic              daily_alarm_irq_n_oe,
  output logic              crystal_clock_out_oe
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0]       ctrl_ff,  nxt_ctrl;
  logic [7:0]       flag_ff,  nxt_flag;
  logic [DIV_W-1:0] div_ff,   nxt_div;
  logic             xs1_ff, xs2_ff, xs3_ff;
  logic             gate_ff,  nxt_gate;
  logic             tick_ff;
  logic [7:0]       rd_ff;
  logic             per_oe_ff, week_oe_ff, day_oe_ff, clk_oe_ff;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  function automatic logic wr_hit(input rtcirq_wr_s w, input logic [3:0] a);
    return w.valid && (w.addr == a);
  endfunction

  wire       wr_ctrl   = wr_hit(host_wr, ADDR_IRQ_CTRL);
  wire       wr_flag   = wr_hit(host_wr, ADDR_IRQ_FLAG);
  wire       wr_sec    = wr_hit(host_wr, ADDR_SECONDS);
  wire [2:0] sel       = ctrl_ff[SEL_LSB +: SEL_W];
  wire       lvl_mode  = sel[2];
  wire       xtal_rise = xs2_ff & ~xs3_ff;
  wire       at_tick   = xtal_rise && (div_ff == SEC_TICK_DIV);

  // level-mode event select
  wire lvl_event = at_tick && lvl_mode &&
                   ((sel == SEL_SEC) ||
                    (sel == SEL_MIN   && roll.roll_sec00) ||
                    (sel == SEL_HOUR  && roll.roll_sec00 && roll.roll_min00) ||
                    (sel == SEL_MONTH && roll.roll_sec00 && roll.roll_min00 &&
                                         roll.roll_hour00 && roll.roll_mday1));

  // ----------------------------------------------------------------------
  // sub-second divider
  // ----------------------------------------------------------------------
  // adjustment holds or double-steps the divider on each rising crystal edge while its input is high; the
  // crystal clock output itself is never touched by it
  always_comb begin
    nxt_div = div_ff;
    if (wr_sec) begin
      nxt_div = '0;
    end else if (xtal_rise) begin
      if (adj_lengthen) begin
        nxt_div = div_ff;
      end else if (adj_shorten) begin
        nxt_div = div_ff + DIV_W'(2);
      end else begin
        nxt_div = div_ff + DIV_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // control and flag registers
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_flag = flag_ff;
    if (wr_ctrl) begin
      nxt_ctrl = host_wr.data;
    end
    if (wr_flag) begin
      nxt_flag = (flag_ff & ~FLAG_KEEP_MASK) | (host_wr.data & FLAG_KEEP_MASK);
      nxt_flag[BIT_CLKEN_N_A] = host_wr.data[BIT_CLKEN_N_A];
      // writing one leaves a flag alone, writing zero clears it
      nxt_flag[BIT_PER_FLAG]  = flag_ff[BIT_PER_FLAG]  & host_wr.data[BIT_PER_FLAG];
      nxt_flag[BIT_WEEK_FLAG] = flag_ff[BIT_WEEK_FLAG] & host_wr.data[BIT_WEEK_FLAG];
      nxt_flag[BIT_DAY_FLAG]  = flag_ff[BIT_DAY_FLAG]  & host_wr.data[BIT_DAY_FLAG];
    end
    // sets come after the clear so a coincident event is kept, unless osc_halt_flag clears it in the same cycle
    if (week_alarm_match && ctrl_ff[BIT_WEEK_EN]) begin
      nxt_flag[BIT_WEEK_FLAG] = 1'b1;
    end
    if (daily_alarm_match && ctrl_ff[BIT_DAILY_EN]) begin
      nxt_flag[BIT_DAY_FLAG] = 1'b1;
    end
    if (lvl_event || (wr_sec && lvl_mode)) begin
      nxt_flag[BIT_PER_FLAG] = 1'b1;
    end
    if (osc_halt_flag) begin
      nxt_ctrl = nxt_ctrl & CTRL_KEEP_MASK;
      nxt_flag = nxt_flag & FLAG_KEEP_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // crystal clock output gating
  // ----------------------------------------------------------------------
  // gate only moves while the crystal is high, i.e. while the pin is already
  // released, so a low phase is always output whole or not at all
  wire clk_run = ~(ctrl_ff[BIT_CLKEN_N_B] & flag_ff[BIT_CLKEN_N_A]);
  assign nxt_gate = xs2_ff ? clk_run : gate_ff;

  // ----------------------------------------------------------------------
  // pin pull-down enables
  // ----------------------------------------------------------------------
  logic nxt_per_oe;
  always_comb begin
    unique case (sel)
      SEL_OFF: nxt_per_oe = 1'b0;
      SEL_LOW: nxt_per_oe = 1'b1;
      SEL_2HZ: nxt_per_oe = ~nxt_div[BIT_2HZ];
      SEL_1HZ: nxt_per_oe = ~nxt_div[BIT_1HZ];
      SEL_SEC, SEL_MIN, SEL_HOUR, SEL_MONTH:
               nxt_per_oe = nxt_flag[BIT_PER_FLAG];
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xs1_ff <= 1'b0;
      xs2_ff <= 1'b0;
      xs3_ff <= 1'b0;
    end else if (ce) begin
      xs1_ff <= xtal_in;
      xs2_ff <= xs1_ff;
      xs3_ff <= xs2_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RESET;
      flag_ff <= FLAG_RESET;
      div_ff  <= '0;
      gate_ff <= 1'b0;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
      flag_ff <= nxt_flag;
      div_ff  <= nxt_div;
      gate_ff <= nxt_gate;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      per_oe_ff  <= 1'b0;
      week_oe_ff <= 1'b0;
      day_oe_ff  <= 1'b0;
      clk_oe_ff  <= 1'b0;
      tick_ff    <= 1'b0;
      rd_ff      <= 8'h00;
    end else if (ce) begin
      per_oe_ff  <= nxt_per_oe;
      week_oe_ff <= nxt_flag[BIT_WEEK_FLAG];
      day_oe_ff  <= nxt_flag[BIT_DAY_FLAG];
      clk_oe_ff  <= nxt_gate & ~xs2_ff;
      tick_ff    <= at_tick && !wr_sec;
      rd_ff      <= (host_rd_addr == ADDR_IRQ_CTRL) ? ctrl_ff :
                    (host_rd_addr == ADDR_IRQ_FLAG) ? flag_ff : 8'h00;
    end
  end

  assign host_rd_data         = rd_ff;
  assign sec_tick             = tick_ff;
  assign od_o                 = 4'h0;
  assign periodic_irq_n_oe    = per_oe_ff;
  assign week_alarm_irq_n_oe  = week_oe_ff;
  assign daily_alarm_irq_n_oe = day_oe_ff;
  assign crystal_clock_out_oe = clk_oe_ff;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_week_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    ce && week_alarm_match && ctrl_ff[BIT_WEEK_EN] && !osc_halt_flag
      |=> flag_ff[BIT_WEEK_FLAG] && week_alarm_irq_n_oe)
    else $error("week alarm match did not raise flag and pin");

  a_day_disabled: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !flag_ff[BIT_DAY_FLAG] && !ctrl_ff[BIT_DAILY_EN] && !wr_flag
      |=> !flag_ff[BIT_DAY_FLAG])
    else $error("disabled daily alarm raised its flag");

  a_flag_one_noop: assert property (@(posedge clk) disable iff (!rst_n)
    ce && wr_flag && !flag_ff[BIT_WEEK_FLAG] && host_wr.data[BIT_WEEK_FLAG]
      && !week_alarm_match |=> !flag_ff[BIT_WEEK_FLAG])
    else $error("writing one set the week alarm flag");

  a_clear_keeps_en: assert property (@(posedge clk) disable iff (!rst_n)
    ce && wr_flag && !wr_ctrl && !osc_halt_flag
      |=> ctrl_ff[BIT_WEEK_EN] == $past(ctrl_ff[BIT_WEEK_EN]))
    else $error("flag write changed an alarm enable");

  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    ce && wr_flag && !host_wr.data[BIT_DAY_FLAG] && daily_alarm_match
      && ctrl_ff[BIT_DAILY_EN] && !osc_halt_flag |=> flag_ff[BIT_DAY_FLAG])
    else $error("daily alarm event lost against clear");

  a_halt_clears: assert property (@(posedge clk) disable iff (!rst_n)
    ce && osc_halt_flag |=> ctrl_ff[SEL_LSB +: SEL_W] == SEL_OFF
      && flag_ff[2:0] == 3'h0 && !ctrl_ff[BIT_WEEK_EN] && !ctrl_ff[BIT_DAILY_EN])
    else $error("oscillation halt did not clear controls");

  a_level_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ce && lvl_mode && flag_ff[BIT_PER_FLAG] && !wr_ctrl && !osc_halt_flag
      && !(wr_flag && !host_wr.data[BIT_PER_FLAG]) |=> periodic_irq_n_oe)
    else $error("level interrupt released without clear");

  a_sec_write_low: assert property (@(posedge clk) disable iff (!rst_n)
    ce && wr_sec && (sel == SEL_2HZ || sel == SEL_1HZ) && !wr_ctrl && !osc_halt_flag
      |=> div_ff == '0 ##0 periodic_irq_n_oe)
    else $error("seconds write did not reset divider and drive low");

  a_off_released: assert property (@(posedge clk) disable iff (!rst_n)
    ce && sel == SEL_OFF && !wr_ctrl |=> !periodic_irq_n_oe)
    else $error("periodic pin driven while disabled");

  a_clkout_stop: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !clk_run && !gate_ff |=> !crystal_clock_out_oe)
    else $error("clock output driven while stopped");

endmodule // rtcirq_core

/* File: hdl/rtcirq_pkg.sv */
// package for the interrupt and clock-output logic of the real-time clock
// assumes one 10 MHz system clock and a register write port fed by the serial bus slave
package rtcirq_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_SECONDS  = 4'h0;
  localparam logic [3:0] ADDR_IRQ_CTRL = 4'hE;  // interrupt_enable_select_control
  localparam logic [3:0] ADDR_IRQ_FLAG = 4'hF;  // interrupt_flag_status_control

  // interrupt_enable_select_control fields
  localparam int BIT_WEEK_EN   = 7;
  localparam int BIT_DAILY_EN  = 6;
  localparam int BIT_CLKEN_N_B = 4;
  localparam int SEL_LSB       = 0;
  localparam int SEL_W         = 3;
  // interrupt_flag_status_control fields
  localparam int BIT_CLKEN_N_A = 3;
  localparam int BIT_PER_FLAG  = 2;
  localparam int BIT_WEEK_FLAG = 1;
  localparam int BIT_DAY_FLAG  = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  // bits of the two registers held as plain storage here
  localparam logic [7:0] CTRL_KEEP_MASK = 8'h28;
  localparam logic [7:0] FLAG_KEEP_MASK = 8'hF0;

  // ----------------------------------------------------------------------
  // periodic select codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEL_OFF   = 3'h0;
  localparam logic [2:0] SEL_LOW   = 3'h1;
  localparam logic [2:0] SEL_2HZ   = 3'h2;
  localparam logic [2:0] SEL_1HZ   = 3'h3;
  localparam logic [2:0] SEL_SEC   = 3'h4;
  localparam logic [2:0] SEL_MIN   = 3'h5;
  localparam logic [2:0] SEL_HOUR  = 3'h6;
  localparam logic [2:0] SEL_MONTH = 3'h7;

  // ----------------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------------
  localparam int         XTAL_HZ      = 32768;
  localparam int         DIV_W        = 15;
  localparam int         TICK_DELAY_US = 92;
  // crystal edges from pulse fall to seconds increment, rounded down
  localparam logic [14:0] SEC_TICK_DIV =
    15'((TICK_DELAY_US * XTAL_HZ) / 1000000);
  localparam int         BIT_2HZ      = 13;
  localparam int         BIT_1HZ      = 14;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [3:0] addr;
    logic [7:0] data;
  } rtcirq_wr_s;

  typedef struct packed {
    logic roll_sec00;
    logic roll_min00;
    logic roll_hour00;
    logic roll_mday1;
  } rtcirq_roll_s;

endpackage
